/* File: rtl/ddcm_pkg.sv */
/*
 * shared constants for the downconverter: register map, control fields,
 * fixed-point scale factors and the frequency translation mode encoding.
 * assumes a 32-bit apb register bus and 16-bit converter samples.
 */
package ddcm_pkg;
	localparam int DW   = 16;
	localparam int AW   = DW + 4;
	localparam int PW   = 12;
	localparam int FRAC = 15;

	localparam logic [11:0] A_SYNC   = 12'h000;
	localparam logic [11:0] A_CHIP   = 12'h004;
	localparam logic [11:0] A_STAT   = 12'h008;
	localparam logic [3:0]  OFS_CTRL = 4'h0;
	localparam logic [3:0]  OFS_FREQ = 4'h4;
	localparam logic [3:0]  OFS_PHAS = 4'h8;

	localparam int CT_CPLX = 7;
	localparam int CT_GAIN = 6;
	localparam int CT_IF   = 4;
	localparam int CT_C2R  = 3;
	localparam int CT_DEC  = 0;
	localparam int SY_SOFT = 4;
	localparam int SY_SREF = 2;
	localparam int SY_MODE = 0;
	localparam int ST_CNT  = 0;
	localparam int ST_REAL = 8;
	localparam int ST_SREF = 31;

	localparam logic [2:0] CHIP_LOG_MAX = 3'h4;

	localparam logic signed [DW-1:0] NCO_LOSS_Q15   = 16'sh7f44;
	localparam logic signed [DW-1:0] CPLX_ATTEN_Q15 = 16'sh59fe;
	localparam logic signed [DW-1:0] TEST_LEVEL     = 16'sh7fde;
	localparam logic signed [DW-1:0] FS_MAX         = 16'sh7fff;
	localparam logic signed [DW-1:0] FS_MIN         = 16'sh8000;
	localparam logic [PW-1:0]        QUARTER_STEP   = 12'h400;
	localparam logic [PW-1:0]        COS_OFS        = 12'h400;
	localparam logic signed [PW:0]   HALF_TURN      = 13'sh0800;

	typedef enum logic [1:0] {
		variable_if,
		zero_if_mode,
		quarter_if,
		test_if
	} ddcm_if_e;
endpackage : ddcm_pkg

/* File: rtl/ddcm_nco.sv */
/*
 * one numerically controlled oscillator: phase accumulator with reload
 * and a parabolic sine/cosine generator carrying the fixed oscillator loss.
 * assumes the caller supplies a one-cycle sync pulse on ref_clk.
 */
`timescale 1ns/1ns
module ddcm_nco import ddcm_pkg::*; (
	input  wire logic               ref_clk,           // sample clock
	input  wire logic               rst_n,             // synchronous reset
	input  wire logic               run,               // advance this cycle
	input  wire logic               quarter,           // fixed fs/4 stepping
	input  wire logic               sync,              // reload phase
	input  wire logic [PW-1:0]      freq_tuning_word,  // step per sample
	input  wire logic [PW-1:0]      phase_offset_word, // reload value
	output logic signed [DW-1:0]    cos_o,             // oscillator cosine
	output logic signed [DW-1:0]    sin_o              // oscillator sine
);
	typedef struct packed {
		logic [PW-1:0]        phase_accumulator;
		logic signed [DW-1:0] c;
		logic signed [DW-1:0] s;
	} ddcm_nco_s;

	ddcm_nco_s r;
	ddcm_nco_s next;

	// sine of a signed phase; quarter mode gives exact quadrant values
	function automatic logic signed [DW-1:0] wave(input logic [PW-1:0] ph, input logic q);
		logic signed [PW:0]     x;
		logic signed [PW:0]     ax;
		logic signed [2*PW+1:0] y;
		logic signed [2*DW:0]   z;
		x = signed'({ph[PW-1], ph});
		ax = x[PW] ? -x : x;
		y = x * (HALF_TURN - ax);
		z = signed'(y[DW+5:5]) * NCO_LOSS_Q15;
		if (q) begin
			unique case (ph[PW-1:PW-2])
				2'h1: return NCO_LOSS_Q15;
				2'h3: return -NCO_LOSS_Q15;
				default: return '0;
			endcase
		end
		return z[DW+FRAC-1:FRAC];
	endfunction : wave

	always_comb begin
		next = r;
		if (sync) begin
			next.phase_accumulator = phase_offset_word;
		end else if (run) begin
			next.phase_accumulator = r.phase_accumulator + (quarter ? QUARTER_STEP : freq_tuning_word);
		end
		next.c = wave(r.phase_accumulator + COS_OFS, quarter);
		next.s = wave(r.phase_accumulator, quarter);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next;
		end
	end

	assign cos_o = r.c;
	assign sin_o = r.s;

	property p_sync_load;
		@(posedge ref_clk) disable iff (!rst_n)
		sync |=> r.phase_accumulator == $past(phase_offset_word);
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("phase not reloaded");

	property p_step;
		@(posedge ref_clk) disable iff (!rst_n)
		run && !sync && !quarter |=>
			r.phase_accumulator == PW'($past(r.phase_accumulator) + $past(freq_tuning_word));
	endproperty
	a_step: assert property (p_step) else $error("phase step wrong");

	property p_quarter;
		@(posedge ref_clk) disable iff (!rst_n)
		run && !sync && quarter |=>
			PW'(r.phase_accumulator - $past(r.phase_accumulator)) == QUARTER_STEP;
	endproperty
	a_quarter: assert property (p_quarter) else $error("quarter step wrong");
endmodule : ddcm_nco

/* File: rtl/ddcm_top.sv */
/*
 * multi-channel digital_downconverter: per-channel oscillator and mixer,
 * decimation by averaging stages, complex-to-real option, gain stage and
 * sample repetition to the chip-wide rate, with an apb register file.
 * assumes converter samples arrive from a crossbar on ref_clk, one per
 * in_valid cycle, and that sysref is an asynchronous pin.
 */
// The implementer's own choices: the APB slave port and the register addresses.
//
// Overview of operation
// - slower channels repeat their held sample at each chip-rate output strobe
// - chip decimation of 16 forces complex output on every channel
// - two control bits per channel choose one of four translation modes
// - variable mode runs oscillator and mixer at the tuning word
// - zero mode bypasses the mixer and stops the oscillator
// - quarter mode steps the oscillator by a fixed quarter turn
// - test mode replaces mixer input by 0.999 full scale
// - complex mixing attenuates 3.06 dB; oscillator loses 0.05 dB always
// - tuning word is 12-bit two's complement, wrapping modulo one turn
// - every channel has its own 12-bit phase offset word
// - accumulator reloads from phase offset and adds tuning word per sample
// - soft sync bit written high then low resets all accumulators
// - enabled sysref events reset all accumulators when sync mode nonzero
// - per-channel bit picks real (two products) or complex (four) mixing
// - final stage always on; three earlier stages may be bypassed
// - two control bits per channel select its decimation
// - stages 1..4 give real 1,2,4,8 or complex 2,4,8,16
// - complex-to-real bit gives real output on i port only
// - each channel selects 0 dB or 6 dB output gain
`timescale 1ns/1ns
module ddcm_top import ddcm_pkg::*; #(
	parameter int NUM_CH = 4                           // channel count
) (
	input  wire logic                 ref_clk,         // sample clock
	input  wire logic                 rst_n,           // synchronous reset
	input  wire logic [11:0]          paddr,           // apb byte address
	input  wire logic                 psel,            // apb select
	input  wire logic                 penable,         // apb access phase
	input  wire logic                 pwrite,          // apb write
	input  wire logic [31:0]          pwdata,          // apb write data
	output logic [31:0]               prdata,          // apb read data
	output logic                      pready,          // apb ready
	output logic                      pslverr,         // unmapped address
	input  wire logic                 sysref,          // async sync pin
	input  wire logic                 in_valid,        // converter sample
	input  wire logic [NUM_CH*DW-1:0] in_i,            // i input per channel
	input  wire logic [NUM_CH*DW-1:0] in_q,            // q input per channel
	output logic                      out_valid,       // chip-rate strobe
	output logic [NUM_CH*DW-1:0]      out_i,           // i output per channel
	output logic [NUM_CH*DW-1:0]      out_q,           // q output per channel
	output logic [NUM_CH-1:0]         out_q_valid      // q port carries data
);
	typedef struct packed {
		logic                      ack;
		logic [31:0]               prdata;
		logic [NUM_CH-1:0][7:0]    ctrl;
		logic [NUM_CH-1:0][PW-1:0] freq_tuning_word;
		logic [NUM_CH-1:0][PW-1:0] phase_offset_word;
		logic [2:0]                decimation_ratio;
		logic                      soft_rst;
		logic                      sref_en;
		logic [1:0]                sync_mode;
		logic [2:0]                sref_pipe;
		logic                      sref_level;
		logic                      sync_p;
		logic [7:0]                sync_cnt;
		logic [3:0]                chip_cnt;
		logic [NUM_CH-1:0][3:0]    acc_cnt;
		logic [NUM_CH-1:0][AW-1:0] acc_i;
		logic [NUM_CH-1:0][AW-1:0] acc_q;
		logic [NUM_CH-1:0][1:0]    c2r_ph;
		logic [NUM_CH-1:0][DW-1:0] held_i;
		logic [NUM_CH-1:0][DW-1:0] held_q;
		logic                      out_valid;
		logic [NUM_CH-1:0][DW-1:0] out_i;
		logic [NUM_CH-1:0][DW-1:0] out_q;
		logic [NUM_CH-1:0]         q_valid;
		logic [NUM_CH-1:0]         real_out;
	} ddcm_top_s;

	ddcm_top_s            r;
	ddcm_top_s            next;
	logic                 hit;
	logic signed [DW-1:0] nco_c [NUM_CH];
	logic signed [DW-1:0] nco_s [NUM_CH];
	logic signed [DW-1:0] src_i [NUM_CH];
	logic signed [DW+1:0] mix_i [NUM_CH];

	if (NUM_CH < 1 || NUM_CH > 15) begin : g_bad_ch
		$error("NUM_CH must be 1 to 15");
	end

	// q15 product of an 18-bit sample and a 16-bit factor
	function automatic logic signed [DW+1:0] mulq(input logic signed [DW+1:0] a,
			input logic signed [DW-1:0] b);
		logic signed [2*DW+1:0] p;
		p = a * b;
		return p[DW+1+FRAC:FRAC];
	endfunction : mulq

	function automatic logic [DW-1:0] sat(input logic signed [AW-1:0] v);
		if (v > AW'(FS_MAX)) begin
			return FS_MAX;
		end
		if (v < AW'(FS_MIN)) begin
			return FS_MIN;
		end
		return v[DW-1:0];
	endfunction : sat

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		ddcm_nco u_nco (
			.ref_clk           (ref_clk),
			.rst_n             (rst_n),
			.run               (in_valid && r.ctrl[g][CT_IF+:2] != 2'(zero_if_mode)),
			.quarter           (r.ctrl[g][CT_IF+:2] == 2'(quarter_if)),
			.sync              (r.sync_p),
			.freq_tuning_word  (r.freq_tuning_word[g]),
			.phase_offset_word (r.phase_offset_word[g]),
			.cos_o             (nco_c[g]),
			.sin_o             (nco_s[g])
		);
	end

	always_comb begin
		int                   ci;
		logic                 chv;
		logic                 chip_last;
		logic [3:0]           chip_mask;
		logic [31:0]          rdat;
		ddcm_if_e             mode;
		logic                 cplx;
		logic                 rl;
		logic signed [DW-1:0] xi;
		logic signed [DW-1:0] xq;
		logic signed [DW+1:0] mi;
		logic signed [DW+1:0] mq;
		logic [2:0]           lg;
		logic [3:0]           last;
		logic signed [AW-1:0] si;
		logic signed [AW-1:0] sq;
		logic signed [AW-1:0] ai;
		logic signed [AW-1:0] aq;
		logic signed [AW-1:0] v;
		ci = 0;
		chv = 1'b0;
		chip_last = 1'b0;
		chip_mask = '0;
		rdat = '0;
		mode = variable_if;
		cplx = 1'b0;
		rl = 1'b0;
		xi = '0;
		xq = '0;
		mi = '0;
		mq = '0;
		lg = '0;
		last = '0;
		si = '0;
		sq = '0;
		ai = '0;
		aq = '0;
		v = '0;
		next = r;
		hit = 1'b0;
		next.ack = 1'b0;
		next.sync_p = 1'b0;
		next.out_valid = 1'b0;

		// page 0 holds chip registers, page n holds channel n-1
		chv = paddr[11:8] == 4'h0 && paddr[7:4] != 4'h0 && 32'(paddr[7:4]) <= NUM_CH;
		ci = chv ? int'(paddr[7:4]) - 1 : 0;
		if (paddr == A_SYNC) begin
			hit = 1'b1;
			rdat[SY_SOFT] = r.soft_rst;
			rdat[SY_SREF] = r.sref_en;
			rdat[SY_MODE+:2] = r.sync_mode;
		end else if (paddr == A_CHIP) begin
			hit = 1'b1;
			rdat = 32'(r.decimation_ratio);
		end else if (paddr == A_STAT) begin
			hit = 1'b1;
			rdat[ST_CNT+:8] = r.sync_cnt;
			rdat[ST_REAL+:NUM_CH] = r.real_out;
			rdat[ST_SREF] = r.sref_level;
		end else if (chv) begin
			hit = 1'b1;
			unique case (paddr[3:0])
				OFS_CTRL: rdat = 32'(r.ctrl[ci]);
				OFS_FREQ: rdat = 32'(r.freq_tuning_word[ci]);
				OFS_PHAS: rdat = 32'(r.phase_offset_word[ci]);
				default: hit = 1'b0;
			endcase
		end

		// first access cycle samples read data, second completes
		if (psel && penable && !r.ack) begin
			next.ack = 1'b1;
			next.prdata = rdat;
		end
		if (psel && penable && r.ack && pwrite && hit) begin
			if (paddr == A_SYNC) begin
				next.soft_rst = pwdata[SY_SOFT];
				next.sref_en = pwdata[SY_SREF];
				next.sync_mode = pwdata[SY_MODE+:2];
				if (r.soft_rst && !pwdata[SY_SOFT]) begin
					next.sync_p = 1'b1;
				end
			end else if (paddr == A_CHIP) begin
				if (pwdata[2:0] <= CHIP_LOG_MAX) begin
					next.decimation_ratio = pwdata[2:0];
				end
			end else if (chv) begin
				unique case (paddr[3:0])
					OFS_CTRL: next.ctrl[ci] = pwdata[7:0];
					OFS_FREQ: next.freq_tuning_word[ci] = pwdata[PW-1:0];
					OFS_PHAS: next.phase_offset_word[ci] = pwdata[PW-1:0];
					default: ;
				endcase
			end
		end

		// sysref pin: third and second stage must agree before a change counts
		next.sref_pipe = {r.sref_pipe[1:0], sysref};
		if (r.sref_pipe[2] == r.sref_pipe[1]) begin
			next.sref_level = r.sref_pipe[2];
			if (r.sref_pipe[2] && !r.sref_level && r.sref_en && r.sync_mode != 2'h0) begin
				next.sync_p = 1'b1;
			end
		end
		if (r.sync_p) begin
			next.sync_cnt = r.sync_cnt + 8'h01;
		end

		// chip-wide output strobe
		chip_mask = 4'((5'h01 << r.decimation_ratio) - 5'h01);
		chip_last = in_valid && r.chip_cnt == chip_mask;
		if (r.sync_p) begin
			next.chip_cnt = '0;
		end else if (in_valid) begin
			next.chip_cnt = chip_last ? 4'h0 : r.chip_cnt + 4'h1;
		end

		for (int c = 0; c < NUM_CH; c++) begin
			mode = ddcm_if_e'(r.ctrl[c][CT_IF+:2]);
			cplx = r.ctrl[c][CT_CPLX];
			rl = r.ctrl[c][CT_C2R] && r.decimation_ratio != CHIP_LOG_MAX;
			next.real_out[c] = rl;
			xi = in_i[c*DW+:DW];
			xq = cplx ? signed'(in_q[c*DW+:DW]) : '0;
			if (mode == test_if) begin
				xi = TEST_LEVEL;
				xq = cplx ? TEST_LEVEL : '0;
			end
			src_i[c] = xi;
			if (mode == zero_if_mode) begin
				mi = (DW+2)'(xi);
				mq = (DW+2)'(xq);
			end else if (cplx) begin
				mi = mulq((DW+2)'(mulq((DW+2)'(xi), nco_c[c]) + mulq((DW+2)'(xq), nco_s[c])),
					CPLX_ATTEN_Q15);
				mq = mulq((DW+2)'(mulq((DW+2)'(xq), nco_c[c]) - mulq((DW+2)'(xi), nco_s[c])),
					CPLX_ATTEN_Q15);
			end else begin
				mi = mulq((DW+2)'(xi), nco_c[c]);
				mq = -mulq((DW+2)'(xi), nco_s[c]);
			end
			mix_i[c] = mi;

			// stage count is field+1; real output skips the final downsample
			lg = 3'(r.ctrl[c][CT_DEC+:2]) + (rl ? 3'h0 : 3'h1);
			last = 4'((5'h01 << lg) - 5'h01);
			si = (r.acc_cnt[c] == 4'h0) ? AW'(mi) : signed'(r.acc_i[c]) + AW'(mi);
			sq = (r.acc_cnt[c] == 4'h0) ? AW'(mq) : signed'(r.acc_q[c]) + AW'(mq);
			if (r.sync_p) begin
				next.acc_cnt[c] = '0;
				next.acc_i[c] = '0;
				next.acc_q[c] = '0;
				next.c2r_ph[c] = '0;
			end else if (in_valid) begin
				if (r.acc_cnt[c] == last) begin
					next.acc_cnt[c] = '0;
					ai = si >>> lg;
					aq = sq >>> lg;
					v = ai;
					if (rl) begin
						unique case (r.c2r_ph[c])
							2'h0: v = ai;
							2'h1: v = -aq;
							2'h2: v = -ai;
							2'h3: v = aq;
						endcase
						next.c2r_ph[c] = r.c2r_ph[c] + 2'h1;
						aq = '0;
					end
					if (r.ctrl[c][CT_GAIN]) begin
						v = v <<< 1;
						aq = aq <<< 1;
					end
					next.held_i[c] = sat(v);
					next.held_q[c] = sat(aq);
				end else begin
					next.acc_cnt[c] = r.acc_cnt[c] + 4'h1;
					next.acc_i[c] = si;
					next.acc_q[c] = sq;
				end
			end
			if (chip_last) begin
				next.out_i[c] = next.held_i[c];
				next.out_q[c] = next.held_q[c];
				next.q_valid[c] = !rl;
			end
		end
		if (chip_last) begin
			next.out_valid = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next;
		end
	end

	assign prdata = r.prdata;
	assign pready = psel && penable && r.ack;
	assign pslverr = psel && penable && r.ack && !hit;
	assign out_valid = r.out_valid;
	assign out_i = r.out_i;
	assign out_q = r.out_q;
	assign out_q_valid = r.q_valid;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_repeat;
		out_valid && r.decimation_ratio == 3'h2 |=> !out_valid [*3];
	endproperty
	a_repeat: assert property (p_repeat) else $error("chip strobe too early");

	property p_c16;
		out_valid && r.decimation_ratio == CHIP_LOG_MAX |-> &out_q_valid;
	endproperty
	a_c16: assert property (p_c16) else $error("real output at top ratio");

	property p_zero_if;
		r.ctrl[0][CT_IF+:2] == 2'(zero_if_mode) |-> mix_i[0] == (DW+2)'(src_i[0]);
	endproperty
	a_zero_if: assert property (p_zero_if) else $error("zero mode translated");

	property p_test;
		r.ctrl[0][CT_IF+:2] == 2'(test_if) |-> src_i[0] == TEST_LEVEL;
	endproperty
	a_test: assert property (p_test) else $error("test level not forced");

	property p_soft;
		pready && pwrite && paddr == A_SYNC && r.soft_rst && !pwdata[SY_SOFT]
			|=> r.sync_p ##1 !r.sync_p;
	endproperty
	a_soft: assert property (p_soft) else $error("soft sync missed");

	property p_sref;
		r.sref_pipe[2] && r.sref_pipe[1] && !r.sref_level && r.sref_en && r.sync_mode != 2'h0
			|=> r.sync_p ##1 r.sync_cnt == 8'($past(r.sync_cnt) + 8'h01);
	endproperty
	a_sref: assert property (p_sref) else $error("sysref sync missed");
endmodule : ddcm_top

/* File: test/ddcm_far_model.sv */
/*
 * far-side model: converter source feeding every channel and an output
 * sink counting chip-rate strobes.
 * assumes ref_clk comes from the bench and inputs change after its edge.
 */
`timescale 1ns/1ns
module ddcm_far_model import ddcm_pkg::*; #(
	parameter int NUM_CH = 4                     // channel count
) (
	input  wire logic                 ref_clk,   // sample clock
	input  wire logic                 rst_n,     // synchronous reset
	input  wire logic                 run,       // stream samples
	input  wire logic                 slow,      // one sample every other cycle
	input  wire logic [DW-1:0]        lvl_i,     // i level
	input  wire logic [DW-1:0]        lvl_q,     // q level
	input  wire logic                 clr,       // clear strobe count
	input  wire logic                 out_valid, // chip-rate strobe
	output logic                      in_valid,  // sample strobe
	output logic [NUM_CH*DW-1:0]      in_i,      // i to every channel
	output logic [NUM_CH*DW-1:0]      in_q,      // q to every channel
	output logic [15:0]               n_out      // strobes seen
);
	logic ph = 1'b0;
	logic go;
	assign go = run & rst_n & (~slow | ph);
	initial begin
		in_valid = 1'b0;
		in_i = '0;
		in_q = '0;
		n_out = 16'h0000;
	end
	always @(posedge ref_clk) begin
		ph <= ~ph & rst_n;
		n_out <= (clr | ~rst_n) ? 16'h0000 : n_out + {15'h0000, out_valid};
		in_valid <= go;
		// between samples the lines invert every cycle, so an even run of idle cycles shows stale data
		in_i <= go ? {NUM_CH{lvl_i}} : ~in_i;
		in_q <= go ? {NUM_CH{lvl_q}} : ~in_q;
	end
endmodule : ddcm_far_model

/* File: test/tb.sv */
/*
 * self-checking bench: apb registers, output rate, translation modes, sync.
 * assumes the design package and the far-side model are compiled first.
 */
`timescale 1ns/1ns
module tb import ddcm_pkg::*;;
	logic               ref_clk, rst_n, psel, penable, pwrite, sysref, re;
	logic               pready, pslverr, in_valid, out_valid, run, slow, clr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rv;
	logic [4*DW-1:0]    in_i, in_q, out_i, out_q;
	logic [3:0]         out_q_valid;
	logic [DW-1:0]      lvl_i, lvl_q;
	logic [15:0]        n_out;
	logic signed [31:0] ex;
	int                 err_count, n_tests, cyc;

	ddcm_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sysref(sysref), .in_valid(in_valid),
		.in_i(in_i), .in_q(in_q), .out_valid(out_valid), .out_i(out_i),
		.out_q(out_q), .out_q_valid(out_q_valid));
	ddcm_far_model far (.ref_clk(ref_clk), .rst_n(rst_n), .run(run), .slow(slow),
		.lvl_i(lvl_i), .lvl_q(lvl_q), .clr(clr), .out_valid(out_valid),
		.in_valid(in_valid), .in_i(in_i), .in_q(in_q), .n_out(n_out));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic near(input logic [15:0] a, input logic [15:0] b);
		logic signed [16:0] d;
		d = $signed({a[15], a}) - $signed({b[15], b});
		return d > -5 && d < 5;
	endfunction : near

	function automatic logic [15:0] mag(input logic [15:0] v);
		return v[15] ? -v : v;
	endfunction : mag

	// request held until the rising edge at which pready is sampled high;
	// only the bench timeout ends a wait that never completes
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task automatic sync_soft();
		wr(A_SYNC, 32'h10);
		wr(A_SYNC, 32'h00);
	endtask : sync_soft

	task automatic burst(input int n, input logic s);
		@(posedge ref_clk);
		run <= 1'b1;
		slow <= s;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (s ? 2 * n - 1 : n - 1) @(posedge ref_clk);
		run <= 1'b0;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : burst

	task automatic t_regs();
		rd(A_STAT);
		check(rv, 32'h0);
		rd(12'h010);
		check(rv, 32'h0);
		wr(12'h010, 32'h83);
		rd(12'h010);
		check(rv, 32'h83);
		wr(12'h014, 32'hffff_f7ff);
		rd(12'h014);
		check(rv, 32'h7ff);
		wr(12'h018, 32'h0000_0abc);
		rd(12'h018);
		check(rv, 32'habc);
		rd(12'h0fc);
		check({31'h0, re}, 32'h1);
		check(rv, 32'h0);
		wr(A_CHIP, 32'h4);
		wr(A_CHIP, 32'h5);
		rd(A_CHIP);
		check(rv, 32'h4);
	endtask : t_regs

	task automatic t_rate();
		for (int k = 0; k < 5; k++) begin
			for (int c = 1; c < 5; c++) begin
				wr(12'(16 * c), 32'h08 | 32'(k > 3 ? 3 : k));
			end
			wr(A_CHIP, 32'(k));
			sync_soft();
			burst(64, k[0]);
			check({16'h0, n_out}, 32'(64 >> k));
			check({28'h0, out_q_valid}, {28'h0, {4{k == 4}}});
			rd(A_STAT);
			check({28'h0, rv[11:8]}, {28'h0, {4{k != 4}}});
		end
	endtask : t_rate

	task automatic t_mix();
		wr(A_CHIP, 32'h1);
		wr(12'h010, 32'h90);
		lvl_i <= 16'h1000;
		lvl_q <= 16'hf000;
		sync_soft();
		burst(32, 1'b0);
		check(32'(out_i[15:0]), 32'h1000);
		check(32'(out_q[15:0]), 32'hf000);
		wr(12'h010, 32'hd0);
		sync_soft();
		burst(32, 1'b0);
		check(32'(out_i[15:0]), 32'h2000);
		check(32'(out_q[15:0]), 32'he000);
		wr(12'h010, 32'h00);
		wr(12'h014, 32'h0);
		wr(12'h018, 32'h0);
		lvl_i <= 16'h4000;
		sync_soft();
		burst(32, 1'b0);
		ex = (32'sh4000 * NCO_LOSS_Q15) >>> FRAC;
		check(32'(near(out_i[15:0], ex[15:0])), 32'h1);
		check(32'(near(out_q[15:0], 16'h0)), 32'h1);
		wr(12'h010, 32'h20);
		sync_soft();
		burst(32, 1'b0);
		check(32'(near(mag(out_i[15:0]), ex[16:1])), 32'h1);
		wr(12'h010, 32'h80);
		sync_soft();
		burst(32, 1'b0);
		ex = (ex * CPLX_ATTEN_Q15) >>> FRAC;
		check(32'(near(out_i[15:0], ex[15:0])), 32'h1);
		wr(12'h010, 32'h30);
		sync_soft();
		burst(32, 1'b0);
		ex = (TEST_LEVEL * NCO_LOSS_Q15) >>> FRAC;
		check(32'(near(out_i[15:0], ex[15:0])), 32'h1);
		wr(12'h018, 32'h400);
		sync_soft();
		burst(32, 1'b0);
		ex = -ex;
		check(32'(near(out_i[15:0], 16'h0)), 32'h1);
		check(32'(near(out_q[15:0], ex[15:0])), 32'h1);
	endtask : t_mix

	task automatic pulse_sref();
		@(posedge ref_clk);
		sysref <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(A_STAT);
		sysref <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : pulse_sref

	task automatic t_sync();
		logic [7:0] c0;
		rd(A_STAT);
		c0 = rv[7:0];
		wr(A_SYNC, 32'h10);
		rd(A_STAT);
		check(32'(rv[7:0]), 32'(c0));
		wr(A_SYNC, 32'h00);
		rd(A_STAT);
		check(32'(rv[7:0]), 32'(c0 + 8'h1));
		wr(A_SYNC, 32'h05);
		pulse_sref();
		check({31'h0, rv[31]}, 32'h1);
		check(32'(rv[7:0]), 32'(c0 + 8'h2));
		wr(A_SYNC, 32'h04);
		pulse_sref();
		check(32'(rv[7:0]), 32'(c0 + 8'h2));
	endtask : t_sync

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, sysref, run, slow, clr} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		lvl_i = 16'h0;
		lvl_q = 16'h0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_rate();
		t_mix();
		t_sync();
		end_of_test();
	end
endmodule : tb
